// ===== sim/adcdef_vic_model.sv
// Behavioural model of the top-level vector controller fed by the block's request.
// Assumes it shares aclk and aresetn with the block.
`timescale 1ns/1ns
module adcdef_vic_model #(
   parameter logic [7:0] VECTOR = 8'h10  // Arbitrary slot number for this peripheral.
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       periph_enable,
   input  wire logic       periph_irq,
   output logic            vector_valid,
   output logic [7:0]      vector_num
);
   // Only the peripheral as a whole is gated here, so source choice stays with the block.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vector_valid <= 1'b0;
         vector_num   <= 8'h00;
      end else begin
         vector_valid <= periph_irq && periph_enable;
         vector_num   <= (periph_irq && periph_enable) ? VECTOR : 8'h00;
      end
   end
endmodule // adcdef_vic_model

// ===== sim/testbench.sv
// Self-checking bench for the ADC event flags, their enables and the DMA count.
// Assumes an AXI4-Lite slave on aclk and single-cycle event strobes.
`timescale 1ns/1ns
module testbench;
   localparam logic [31:0] A_PEN = adcdef_pkg::ADDR_FLAG_PENDING;
   localparam logic [31:0] A_ENA = adcdef_pkg::ADDR_FLAG_ENABLE;
   localparam logic [31:0] A_CNT = adcdef_pkg::ADDR_DMA_RESULT_COUNT;
   localparam logic [31:0] A_BAD = 32'h4000a814;
   logic        aclk;
   logic        aresetn;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq, ovr;
   logic        res_ev, sat_ev, dma_act, wr_pulse, dma_rst, wrap, p_en, vec_valid;
   logic [31:0] awaddr, wdata, araddr, rdata, rd_val;
   logic [1:0]  bresp, rresp, resp;
   logic [12:0] bsize;
   logic [7:0]  vec;
   int          error_cnt, compares, cycles;

   always #4 aclk = ~aclk;

   adcdef_top uut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .result_ready_event(res_ev), .saturation_event(sat_ev),
      .dma_active(dma_act), .dma_write_pulse(wr_pulse), .dma_reset(dma_rst),
      .dma_wrap_mode(wrap), .buffer_size(bsize), .dma_overrun_status(ovr),
      .adc_irq(irq)
   );

   adcdef_vic_model vic (
      .aclk(aclk), .aresetn(aresetn), .periph_enable(p_en), .periph_irq(irq),
      .vector_valid(vec_valid), .vector_num(vec)
   );

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rd_val = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // Strobe bits are {dma reset, write pulse, saturation, result ready}, one cycle long.
   task automatic ev(input logic [3:0] m);
      @(posedge aclk);
      {dma_rst, wr_pulse, sat_ev, res_ev} <= m;
      @(posedge aclk);
      {dma_rst, wr_pulse, sat_ev, res_ev} <= 4'h0;
   endtask

   task automatic complete_run;
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // The whole sequence needs well under a thousand cycles.
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         complete_run();
      end
   end

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {res_ev, sat_ev, wr_pulse, dma_rst, wrap, dma_act} = 6'h00;
      {awaddr, wdata, araddr} = 96'h0;
      p_en = 1'b1;
      bsize = 13'h0004;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_PEN); check(rd_val, 32'h0);
      rd(A_ENA); check(rd_val, 32'h0);
      rd(A_CNT); check(rd_val, 32'h0);
      rd(A_BAD); check({30'h0, resp}, 32'h2);
      check(rd_val, 32'h0);
      wr(A_BAD, 32'h1f); check({30'h0, resp}, 32'h2);
      wr(A_ENA, 32'hffffffff); check({30'h0, resp}, 32'h0);
      rd(A_ENA); check(rd_val, 32'h1f);
      ev(4'h2);
      @(negedge aclk); check(32'(irq), 32'h1);
      @(negedge aclk); check({31'h0, vec_valid}, 32'h1);
      check({24'h0, vec}, 32'h10);
      @(posedge aclk);
      p_en <= 1'b0;
      @(posedge aclk);
      @(negedge aclk); check({31'h0, vec_valid}, 32'h0);
      p_en <= 1'b1;
      rd(A_PEN); check(rd_val, 32'h08);
      wr(A_PEN, 32'h0);
      rd(A_PEN); check(rd_val, 32'h08);
      wr(A_PEN, 32'h08);
      rd(A_PEN); check(rd_val, 32'h0);
      check(32'(irq), 32'h0);
      ev(4'h1);
      @(negedge aclk); check(32'(ovr), 32'h1);
      rd(A_PEN); check(rd_val, 32'h11);
      wr(A_PEN, 32'h11);
      wr(A_ENA, 32'h1e);
      @(posedge aclk);
      dma_act <= 1'b1;
      ev(4'h1);
      rd(A_PEN); check(rd_val, 32'h01);
      check(32'(irq), 32'h0);
      wr(A_ENA, 32'h01);
      @(negedge aclk); check(32'(irq), 32'h1);
      wr(A_PEN, 32'h01);
      repeat (2) ev(4'h4);
      rd(A_PEN); check(rd_val, 32'h02);
      repeat (2) ev(4'h4);
      rd(A_PEN); check(rd_val, 32'h06);
      rd(A_CNT); check(rd_val, 32'h4);
      ev(4'h4);
      wr(A_CNT, 32'h55); check({30'h0, resp}, 32'h0);
      rd(A_CNT); check(rd_val, 32'h4);
      ev(4'h8);
      rd(A_CNT); check(rd_val, 32'h0);
      check(32'(ovr), 32'h0);
      wrap <= 1'b1;
      repeat (3) ev(4'h4);
      rd(A_CNT); check(rd_val, 32'h3);
      ev(4'h4);
      rd(A_CNT); check(rd_val, 32'h0);
      complete_run();
   end
endmodule // testbench

// ===== verilog/adcdef_counter.sv
// DMA progress counter with buffer-full and half-full event detection.
// Assumes write_pulse marks one 16-bit result stored by the DMA engine.
`timescale 1ns/1ns
module adcdef_counter (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   adcdef_dma_if.counter   dma
);
   logic [adcdef_pkg::COUNT_W-1:0] count;
   logic [adcdef_pkg::COUNT_W-1:0] count_inc;
   logic [adcdef_pkg::COUNT_W-1:0] half_size;
   logic                           stopped;
   logic                           reach_full;
   logic                           reach_half;
   logic                           full_event;
   logic                           half_event;

   assign count_inc  = count + adcdef_pkg::COUNT_ONE;
   assign half_size  = dma.buffer_size >> 1;
   // In linear mode the DMA halts once full, so further strobes are ignored.
   assign stopped    = !dma.wrap_mode && (count == dma.buffer_size);
   // A zero-sized buffer never fills, even when the count rolls over in wrap mode.
   assign reach_full = dma.write_pulse && !stopped && (dma.buffer_size != adcdef_pkg::COUNT_RESET)
                       && (count_inc == dma.buffer_size);
   assign reach_half = dma.write_pulse && !stopped && (half_size != adcdef_pkg::COUNT_RESET)
                       && (count_inc == half_size);

   always_ff @(posedge aclk) begin
      if (!aresetn || dma.dma_reset) begin
         count <= adcdef_pkg::COUNT_RESET;
      end else if (dma.write_pulse && !stopped) begin
         if (reach_full && dma.wrap_mode) begin
            count <= adcdef_pkg::COUNT_RESET;
         end else begin
            count <= count_inc;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || dma.dma_reset) begin
         full_event <= 1'b0;
         half_event <= 1'b0;
      end else begin
         full_event <= reach_full;
         half_event <= reach_half;
      end
   end

   assign dma.count      = count;
   assign dma.full_event = full_event;
   assign dma.half_event = half_event;

   linear_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (stopped && !dma.dma_reset) |=> (count == $past(count)))
      else $error("Counter moved after linear buffer filled.");

endmodule // adcdef_counter

// ===== verilog/adcdef_dma_if.sv
// Interface between the event-flag top and its DMA result counter.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface adcdef_dma_if;
   logic                               write_pulse;
   logic                               dma_reset;
   logic                               wrap_mode;
   logic [adcdef_pkg::COUNT_W-1:0]     buffer_size;
   logic [adcdef_pkg::COUNT_W-1:0]     count;
   logic                               full_event;
   logic                               half_event;

   modport counter (
      input  write_pulse,
      input  dma_reset,
      input  wrap_mode,
      input  buffer_size,
      output count,
      output full_event,
      output half_event
   );

   modport ctrl (
      output write_pulse,
      output dma_reset,
      output wrap_mode,
      output buffer_size,
      input  count,
      input  full_event,
      input  half_event
   );
endinterface

// ===== verilog/adcdef_pkg.sv
// Constants shared by the ADC event-flag block and its DMA progress counter.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package adcdef_pkg;

   // Register byte addresses.
   localparam logic [31:0] ADDR_FLAG_PENDING     = 32'h4000a810;
   localparam logic [31:0] ADDR_FLAG_ENABLE      = 32'h4000a850;
   localparam logic [31:0] ADDR_DMA_RESULT_COUNT = 32'h4000d024;

   // Bus geometry.
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;

   // Event source bit positions, shared by the pending and enable registers.
   localparam int NUM_SRC       = 5;
   localparam int BIT_OVERFLOW  = 4;
   localparam int BIT_SATURATE  = 3;
   localparam int BIT_FULL      = 2;
   localparam int BIT_HALF      = 1;
   localparam int BIT_DATA      = 0;

   // DMA result counter width, counted in 16-bit results.
   localparam int COUNT_W = 13;

   // Reset values and the count step.
   localparam logic [NUM_SRC-1:0] FLAG_RESET  = 5'h00;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 13'h0000;
   localparam logic [COUNT_W-1:0] COUNT_ONE   = 13'h0001;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Read channel states.
   typedef enum logic [1:0] {
      RD_IDLE = 2'h1,
      RD_RESP = 2'h2
   } adcdef_rd_state_t;

endpackage

// ===== verilog/adcdef_top.sv
// Second-level event flags of the ADC with DMA, their enables and the DMA count.
// Assumes an AXI4-Lite master and single-cycle event strobes on aclk.
//
// What this block does
// - Read-only 13-bit count of 16-bit results the DMA has stored.
// - Overflow pending flag at bit 4 sets on DMA buffer overflow.
// - Saturation pending flag at bit 3 sets when gain correction saturates.
// - Buffer-full pending flag at bit 2 sets when the buffer fills.
// - Half-full pending flag at bit 1 sets at half buffer.
// - Data pending flag at bit 0 sets when a new result arrives.
// - Enable register holds one read-write enable per source, same bits.
// - Reset clears all pending flags, enables and the result count.
// - All sources merge into one top-level peripheral request.
// - The merged request owns its own top-level vector.
// - Overflow means a result became ready while the DMA is idle.
// - Full and half-full compare against buffer size in results.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
module adcdef_top (
   input  wire logic                               aclk,
   input  wire logic                               aresetn,
   input  wire logic [adcdef_pkg::ADDR_W-1:0]      s_axi_awaddr,
   input  wire logic [2:0]                         s_axi_awprot,
   input  wire logic                               s_axi_awvalid,
   output logic                                    s_axi_awready,
   input  wire logic [adcdef_pkg::DATA_W-1:0]      s_axi_wdata,
   input  wire logic [adcdef_pkg::STRB_W-1:0]      s_axi_wstrb,
   input  wire logic                               s_axi_wvalid,
   output logic                                    s_axi_wready,
   output logic [1:0]                              s_axi_bresp,
   output logic                                    s_axi_bvalid,
   input  wire logic                               s_axi_bready,
   input  wire logic [adcdef_pkg::ADDR_W-1:0]      s_axi_araddr,
   input  wire logic [2:0]                         s_axi_arprot,
   input  wire logic                               s_axi_arvalid,
   output logic                                    s_axi_arready,
   output logic [adcdef_pkg::DATA_W-1:0]           s_axi_rdata,
   output logic [1:0]                              s_axi_rresp,
   output logic                                    s_axi_rvalid,
   input  wire logic                               s_axi_rready,
   input  wire logic                               result_ready_event,
   input  wire logic                               saturation_event,
   input  wire logic                               dma_active,
   input  wire logic                               dma_write_pulse,
   input  wire logic                               dma_reset,
   input  wire logic                               dma_wrap_mode,
   input  wire logic [adcdef_pkg::COUNT_W-1:0]     buffer_size,
   output logic                                    dma_overrun_status,
   output logic                                    adc_irq
);

   function automatic logic addr_hit(input logic [adcdef_pkg::ADDR_W-1:0] addr,
                                     input logic [adcdef_pkg::ADDR_W-1:0] target);
      addr_hit = (addr[adcdef_pkg::ADDR_W-1:2] == target[adcdef_pkg::ADDR_W-1:2]);
   endfunction

   adcdef_dma_if dma ();

   logic [adcdef_pkg::NUM_SRC-1:0]   flag_pending;
   logic [adcdef_pkg::NUM_SRC-1:0]   flag_enable;
   logic [adcdef_pkg::NUM_SRC-1:0]   next_pending;
   logic [adcdef_pkg::NUM_SRC-1:0]   src_event;
   logic [adcdef_pkg::NUM_SRC-1:0]   pend_clear;
   logic                             overflow_event;
   logic                             buffer_full_event;
   logic                             buffer_half_event;
   logic [adcdef_pkg::COUNT_W-1:0]   results_written_count;

   // Write channel holding registers; address and data may arrive in either order.
   logic                             aw_held;
   logic                             w_held;
   logic [adcdef_pkg::ADDR_W-1:0]    aw_addr;
   logic [adcdef_pkg::DATA_W-1:0]    w_data;
   logic [adcdef_pkg::STRB_W-1:0]    w_strb;
   logic                             wr_fire;
   logic                             wr_pending_hit;
   logic                             wr_enable_hit;
   logic                             wr_count_hit;

   adcdef_pkg::adcdef_rd_state_t     rd_state;
   logic                             rd_fire;

   // DMA counter hookup.
   assign dma.write_pulse = dma_write_pulse;
   assign dma.dma_reset   = dma_reset;
   assign dma.wrap_mode   = dma_wrap_mode;
   assign dma.buffer_size = buffer_size;

   adcdef_counter u_counter (
      .aclk    (aclk),
      .aresetn (aresetn),
      .dma     (dma)
   );

   assign results_written_count = dma.count;
   assign buffer_full_event     = dma.full_event;
   assign buffer_half_event     = dma.half_event;

   // Event sources.
   assign overflow_event = result_ready_event && !dma_active;

   assign src_event[adcdef_pkg::BIT_OVERFLOW] = overflow_event;
   assign src_event[adcdef_pkg::BIT_SATURATE] = saturation_event;
   assign src_event[adcdef_pkg::BIT_FULL]     = buffer_full_event;
   assign src_event[adcdef_pkg::BIT_HALF]     = buffer_half_event;
   assign src_event[adcdef_pkg::BIT_DATA]     = result_ready_event;

   // The overrun status is not software-clearable; only a DMA reset or aresetn drops it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_overrun_status <= 1'b0;
      end else if (overflow_event) begin
         dma_overrun_status <= 1'b1;
      end else if (dma_reset) begin
         dma_overrun_status <= 1'b0;
      end
   end

   // AXI write path.
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

   assign wr_pending_hit = wr_fire && addr_hit(aw_addr, adcdef_pkg::ADDR_FLAG_PENDING);
   assign wr_enable_hit  = wr_fire && addr_hit(aw_addr, adcdef_pkg::ADDR_FLAG_ENABLE);
   assign wr_count_hit   = wr_fire && addr_hit(aw_addr, adcdef_pkg::ADDR_DMA_RESULT_COUNT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   // The count register is read-only, so a write to it is accepted and dropped.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= adcdef_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_pending_hit || wr_enable_hit || wr_count_hit) ?
                         adcdef_pkg::RESP_OKAY : adcdef_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_enable <= adcdef_pkg::FLAG_RESET;
      end else if (wr_enable_hit && w_strb[0]) begin
         flag_enable <= w_data[adcdef_pkg::NUM_SRC-1:0];
      end
   end

   // Pending flags: write-one-to-clear, with a same-cycle event taking priority.
   assign pend_clear = (wr_pending_hit && w_strb[0]) ?
                       w_data[adcdef_pkg::NUM_SRC-1:0] : adcdef_pkg::FLAG_RESET;

   genvar gi;
   generate
      for (gi = 0; gi < adcdef_pkg::NUM_SRC; gi++) begin : g_pend
         assign next_pending[gi] = src_event[gi] | (flag_pending[gi] & ~pend_clear[gi]);
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_pending <= adcdef_pkg::FLAG_RESET;
      end else begin
         flag_pending <= next_pending;
      end
   end

   // One merged level request feeds the peripheral's own top-level vector.
   assign adc_irq = |(flag_pending & flag_enable);

   // AXI read path.
   assign s_axi_arready = (rd_state == adcdef_pkg::RD_IDLE);
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= adcdef_pkg::RD_IDLE;
      end else begin
         unique case (rd_state)
            adcdef_pkg::RD_IDLE: begin
               if (rd_fire) begin
                  rd_state <= adcdef_pkg::RD_RESP;
               end
            end
            adcdef_pkg::RD_RESP: begin
               if (s_axi_rready) begin
                  rd_state <= adcdef_pkg::RD_IDLE;
               end
            end
            default: begin
               rd_state <= adcdef_pkg::RD_IDLE;
            end
         endcase
      end
   end

   assign s_axi_rvalid = (rd_state == adcdef_pkg::RD_RESP);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rdata <= '0;
         s_axi_rresp <= adcdef_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rresp <= adcdef_pkg::RESP_OKAY;
         if (addr_hit(s_axi_araddr, adcdef_pkg::ADDR_FLAG_PENDING)) begin
            s_axi_rdata <= 32'(flag_pending);
         end else if (addr_hit(s_axi_araddr, adcdef_pkg::ADDR_FLAG_ENABLE)) begin
            s_axi_rdata <= 32'(flag_enable);
         end else if (addr_hit(s_axi_araddr, adcdef_pkg::ADDR_DMA_RESULT_COUNT)) begin
            s_axi_rdata <= 32'(results_written_count);
         end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= adcdef_pkg::RESP_SLVERR;
         end
      end
   end

   // Checks.
   reset_clear_a: assert property (@(posedge aclk)
      !aresetn |=> (flag_pending == adcdef_pkg::FLAG_RESET && flag_enable == adcdef_pkg::FLAG_RESET
                    && dma.count == adcdef_pkg::COUNT_RESET))
      else $error("State not cleared by reset.");

   overflow_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (result_ready_event && !dma_active) |=> flag_pending[adcdef_pkg::BIT_OVERFLOW]
         && dma_overrun_status)
      else $error("Overflow flag missed.");

   no_false_ovf_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(dma_overrun_status) |-> $past(result_ready_event) && !$past(dma_active))
      else $error("Overrun set without cause.");

   saturate_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      saturation_event |=> flag_pending[adcdef_pkg::BIT_SATURATE])
      else $error("Saturation flag missed.");

   full_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dma.full_event |=> flag_pending[adcdef_pkg::BIT_FULL])
      else $error("Full flag missed.");

   half_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dma.half_event |=> flag_pending[adcdef_pkg::BIT_HALF])
      else $error("Half flag missed.");

   data_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      result_ready_event |=> flag_pending[adcdef_pkg::BIT_DATA])
      else $error("Data flag missed.");

   irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 (adc_irq == |($past(next_pending) & flag_enable)))
      else $error("Request does not follow enabled flags.");

   w1c_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_pending_hit && w_strb[0] && w_data[adcdef_pkg::BIT_DATA] && !result_ready_event)
         |=> !flag_pending[adcdef_pkg::BIT_DATA])
      else $error("Write one did not clear flag.");

   count_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !$stable(dma.count) |-> $past(dma_write_pulse) || $past(dma_reset))
      else $error("Count changed without a DMA write.");

   write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid ##0 !aw_held ##0 !w_held)
      else $error("Write response not raised.");

   reset_idle_a: assert property (@(posedge aclk)
      !aresetn |=> (!s_axi_bvalid && !s_axi_rvalid && !dma_overrun_status && !adc_irq))
      else $error("Outputs not idle after reset.");

   irq_raise_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (saturation_event && flag_enable[adcdef_pkg::BIT_SATURATE] && !wr_enable_hit)
         |=> adc_irq)
      else $error("Enabled event did not raise the request.");

   enable_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_enable_hit && w_strb[0])
         |=> (flag_enable == $past(w_data[adcdef_pkg::NUM_SRC-1:0])))
      else $error("Enable register write lost.");

   enable_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !(wr_enable_hit && w_strb[0]) |=> $stable(flag_enable))
      else $error("Enable register changed without a write.");

   enable_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_fire && addr_hit(s_axi_araddr, adcdef_pkg::ADDR_FLAG_ENABLE))
         |=> (s_axi_rdata == 32'($past(flag_enable))))
      else $error("Enable register read back wrong.");

   pend_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 ((($past(flag_pending) & ~$past(pend_clear)) & ~flag_pending)
           == adcdef_pkg::FLAG_RESET))
      else $error("Pending flag dropped without a write of one.");

   overrun_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (dma_reset && !overflow_event) |=> !dma_overrun_status)
      else $error("Overrun status survived a DMA reset.");

   count_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dma_reset |=> (results_written_count == adcdef_pkg::COUNT_RESET))
      else $error("DMA reset did not clear the count.");

   count_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (dma_write_pulse && !dma_reset && !dma_wrap_mode
         && (results_written_count != buffer_size))
         |=> (results_written_count == $past(results_written_count) + adcdef_pkg::COUNT_ONE))
      else $error("Count did not advance on a DMA write.");

   count_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_fire && addr_hit(s_axi_araddr, adcdef_pkg::ADDR_DMA_RESULT_COUNT))
         |=> (s_axi_rdata == 32'($past(results_written_count))))
      else $error("Count register read back wrong.");

   full_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      buffer_full_event |-> (results_written_count
         == ($past(dma_wrap_mode) ? adcdef_pkg::COUNT_RESET : $past(buffer_size))))
      else $error("Full event away from the buffer end.");

   half_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      buffer_half_event |-> (results_written_count == ($past(buffer_size) >> 1)))
      else $error("Half event away from the buffer middle.");

   read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_fire |=> (s_axi_rvalid && !s_axi_arready))
      else $error("Read response not raised.");

   write_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
      else $error("Write response held after acceptance.");

endmodule // adcdef_top
